// >>> spm_pkg.sv
package spm_pkg;
  // ****************************************
  // register offsets in data space
  // ****************************************
  localparam logic [15:0] SPM_OFS_SEL_A  = 16'h7090;
  localparam logic [15:0] SPM_OFS_SEL_B  = 16'h7092;
  localparam logic [15:0] SPM_OFS_PORT_A = 16'h7098;
  localparam logic [15:0] SPM_OFS_PORT_B = 16'h709A;
  localparam logic [15:0] SPM_OFS_PORT_C = 16'h709C;
  // ****************************************
  // field layouts and reset values
  // ****************************************
  localparam logic [15:0] SPM_RESET_VAL   = 16'h0000;
  localparam logic [15:0] SPM_SEL_A_MASK  = 16'hFF0F;
  localparam logic [15:0] SPM_SEL_B_MASK  = 16'h00FD;
  localparam logic [15:0] SPM_PORT_A_MASK = 16'h0F0F;
  localparam logic [15:0] SPM_PORT_MASK   = 16'hFFFF;
  localparam int          SPM_DIR_POS     = 8;
  localparam int          SPM_B_INVERT_LO = 2;
  localparam int          SPM_B_INVERT_HI = 3;
  localparam logic [7:0]  SPM_B_INV_MASK  = 8'h0C;
  // clock source codes for port c pin one
  localparam logic [1:0]  SPM_CK_GPIO     = 2'h0;
  localparam logic [1:0]  SPM_CK_WDOG     = 2'h1;
  localparam logic [1:0]  SPM_CK_SYS      = 2'h2;
  localparam logic [1:0]  SPM_CK_CPU      = 2'h3;

  // register bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } spm_req_t;

  // peripheral side of eight pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } spm_periph_t;
endpackage

// >>> spm_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
// one port of eight pins: chooses peripheral or gpio per pin
module spm_pin_mux
  import spm_pkg::*;
#(
  parameter int          W   = 8,
  parameter logic [7:0]  INV = 8'h00
) (
  input  wire logic [W-1:0] sel,        // select bits from register
  input  wire logic [W-1:0] dir,        // direction bits
  input  wire logic [W-1:0] dat,        // data bits
  input  wire logic [W-1:0] per_out,    // peripheral drive value
  input  wire logic [W-1:0] per_oe,     // peripheral drive enable
  output logic      [W-1:0] next_out,   // pin value
  output logic      [W-1:0] next_oe     // pin enable
);
  logic [W-1:0] periph;
  // inverted bits pick peripheral when clear
  assign periph = sel ^ INV[W-1:0];
  // gpio drives data only when direction is output
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (periph[i]) begin
        next_out[i] = per_out[i];
        next_oe[i]  = per_oe[i];
      end else begin
        next_out[i] = dat[i];
        next_oe[i]  = dir[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> spm_io_ports.sv
`timescale 1ns/1ps
`default_nettype none
module spm_io_ports
  import spm_pkg::*;
(
  input  wire logic        clk,          // 40 mhz clock
  input  wire logic        arst_n,       // async reset, low
  input  wire spm_req_t    req,          // register access
  output logic      [15:0] rdata,        // read data, registered
  input  wire logic [3:0]  pa_in,        // port a pin levels
  output logic      [3:0]  pa_out,       // port a pin value
  output logic      [3:0]  pa_oe,        // port a pin enable
  input  wire logic [7:0]  pb_in,        // port b pin levels
  output logic      [7:0]  pb_out,       // port b pin value
  output logic      [7:0]  pb_oe,        // port b pin enable
  input  wire logic [7:0]  pc_in,        // port c pin levels
  output logic      [7:0]  pc_out,       // port c pin value
  output logic      [7:0]  pc_oe,        // port c pin enable
  input  wire spm_periph_t per_b,        // port b peripherals
  input  wire spm_periph_t per_c,        // port c peripherals
  input  wire logic [1:0]  clk_out_sel,  // system control clock select
  input  wire logic [2:0]  clk_srcs,     // cpu, sys, watchdog clocks
  output logic [3:0]       sel_analog,   // analog function on port a
  output logic [7:0]       sel_per_c     // port c peripheral select
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] pin_select_group_a;
  logic [15:0] pin_select_group_b;
  logic [15:0] port_a_data_direction;
  logic [15:0] port_b_data_direction;
  logic [15:0] port_c_data_direction;
  logic [7:0]  in_lvl_b, in_lvl_c;
  logic [3:0]  in_lvl_a;
  logic [7:0]  next_pb_out, next_pb_oe, next_pc_out, next_pc_oe;
  logic [7:0]  c_out_m, c_oe_m;
  logic [15:0] next_rdata;

  // register writes, reserved bits held zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_select_group_a    <= SPM_RESET_VAL;
      pin_select_group_b    <= SPM_RESET_VAL;
      port_a_data_direction <= SPM_RESET_VAL;
      port_b_data_direction <= SPM_RESET_VAL;
      port_c_data_direction <= SPM_RESET_VAL;
    end else if (req.wr) begin
      unique case (req.addr)
        SPM_OFS_SEL_A:  pin_select_group_a    <= req.wdata & SPM_SEL_A_MASK;
        SPM_OFS_SEL_B:  pin_select_group_b    <= req.wdata & SPM_SEL_B_MASK;
        SPM_OFS_PORT_A: port_a_data_direction <= req.wdata & SPM_PORT_A_MASK;
        SPM_OFS_PORT_B: port_b_data_direction <= req.wdata;
        SPM_OFS_PORT_C: port_c_data_direction <= req.wdata;
        default: ;
      endcase
    end
  end

  // pin level sampling
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_lvl_a <= 4'h0;
      in_lvl_b <= 8'h00;
      in_lvl_c <= 8'h00;
    end else begin
      in_lvl_a <= pa_in;
      in_lvl_b <= pb_in;
      in_lvl_c <= pc_in;
    end
  end

  // ****************************************
  // readback
  // ****************************************
  // input pins show level, output pins show data
  always_comb begin
    next_rdata = 16'h0000;
    unique case (req.addr)
      SPM_OFS_SEL_A:  next_rdata = pin_select_group_a;
      SPM_OFS_SEL_B:  next_rdata = pin_select_group_b;
      SPM_OFS_PORT_A: next_rdata = {4'h0, port_a_data_direction[11:8], 4'h0,
                        (port_a_data_direction[11:8] & port_a_data_direction[3:0]) |
                        (~port_a_data_direction[11:8] & in_lvl_a)};
      SPM_OFS_PORT_B: next_rdata = {port_b_data_direction[15:8],
                        (port_b_data_direction[15:8] & port_b_data_direction[7:0]) |
                        (~port_b_data_direction[15:8] & in_lvl_b)};
      SPM_OFS_PORT_C: next_rdata = {port_c_data_direction[15:8],
                        (port_c_data_direction[15:8] & port_c_data_direction[7:0]) |
                        (~port_c_data_direction[15:8] & in_lvl_c)};
      default:        next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata <= 16'h0000;
    else if (req.rd) rdata <= next_rdata;
  end

  // ****************************************
  // pin muxes
  // ****************************************
  spm_pin_mux #(.W(8), .INV(8'h00)) u_mux_b (
    .sel      (pin_select_group_a[15:8]),
    .dir      (port_b_data_direction[15:8]),
    .dat      (port_b_data_direction[7:0]),
    .per_out  (per_b.out),
    .per_oe   (per_b.oe),
    .next_out (next_pb_out),
    .next_oe  (next_pb_oe)
  );

  spm_pin_mux #(.W(8), .INV(SPM_B_INV_MASK)) u_mux_c (
    .sel      (pin_select_group_b[7:0]),
    .dir      (port_c_data_direction[15:8]),
    .dat      (port_c_data_direction[7:0]),
    .per_out  (per_c.out),
    .per_oe   (per_c.oe),
    .next_out (c_out_m),
    .next_oe  (c_oe_m)
  );

  // pin one follows clock select, not the mux register
  always_comb begin
    next_pc_out = c_out_m;
    next_pc_oe  = c_oe_m;
    unique case (clk_out_sel)
      SPM_CK_GPIO: begin
        next_pc_out[1] = port_c_data_direction[1];
        next_pc_oe[1]  = port_c_data_direction[9];
      end
      SPM_CK_WDOG: begin
        next_pc_out[1] = clk_srcs[0];
        next_pc_oe[1]  = 1'b1;
      end
      SPM_CK_SYS: begin
        next_pc_out[1] = clk_srcs[1];
        next_pc_oe[1]  = 1'b1;
      end
      SPM_CK_CPU: begin
        next_pc_out[1] = clk_srcs[2];
        next_pc_oe[1]  = 1'b1;
      end
    endcase
  end

  // registered pin drive; analog pins never driven
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_out     <= 4'h0;
      pa_oe      <= 4'h0;
      pb_out     <= 8'h00;
      pb_oe      <= 8'h00;
      pc_out     <= 8'h00;
      pc_oe      <= 8'h00;
      sel_analog <= 4'h0;
      sel_per_c  <= SPM_B_INV_MASK;
    end else begin
      pa_out     <= port_a_data_direction[3:0];
      pa_oe      <= port_a_data_direction[11:8] & ~pin_select_group_a[3:0];
      pb_out     <= next_pb_out;
      pb_oe      <= next_pb_oe;
      pc_out     <= next_pc_out;
      pc_oe      <= next_pc_oe;
      sel_analog <= pin_select_group_a[3:0];
      sel_per_c  <= pin_select_group_b[7:0] ^ SPM_B_INV_MASK;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_port_b_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (!pin_select_group_a[8] && port_b_data_direction[8]) |=>
      (pb_oe[0] && pb_out[0] == $past(port_b_data_direction[0])))
    else $error("port b pin 0 not driven from data");
  a_port_a_analog: assert property (@(posedge clk) disable iff (!arst_n)
    pin_select_group_a[0] |=> !pa_oe[0])
    else $error("analog pin driven");
  a_flag_default: assert property (@(posedge clk) disable iff (!arst_n)
    !pin_select_group_b[2] |=> (pc_out[2] == $past(per_c.out[2])))
    else $error("flag pin not following peripheral");
  a_read_input: assert property (@(posedge clk) disable iff (!arst_n)
    (req.rd && req.addr == SPM_OFS_PORT_B && !port_b_data_direction[8]) |=>
      rdata[0] == $past(in_lvl_b[0]))
    else $error("input level not read back");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    port_a_data_direction[15:12] == 4'h0 && port_a_data_direction[7:4] == 4'h0)
    else $error("port a reserved bits set");
  a_sel_b_res: assert property (@(posedge clk) disable iff (!arst_n)
    pin_select_group_b[15:8] == 8'h00 && !pin_select_group_b[1])
    else $error("select b reserved bits set");
  a_sel_a_res: assert property (@(posedge clk) disable iff (!arst_n)
    pin_select_group_a[7:4] == 4'h0)
    else $error("select a reserved bits set");
  a_clk_pin: assert property (@(posedge clk) disable iff (!arst_n)
    (clk_out_sel == SPM_CK_SYS) |=> (pc_oe[1] && pc_out[1] == $past(clk_srcs[1])))
    else $error("clock pin not selected");
  c_write_b: cover property (@(posedge clk) req.wr && req.addr == SPM_OFS_PORT_B);
  c_read_c:  cover property (@(posedge clk) req.rd && req.addr == SPM_OFS_PORT_C);
  c_periph:  cover property (@(posedge clk) pin_select_group_a[15]);
endmodule
`default_nettype wire

// >>> spm_pin_world.sv
`timescale 1ns/1ps
`default_nettype none
// outside circuit on shared pins: one weak driver per pin, device drive wins
module spm_pin_world #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out,  // device pin value
  input  wire logic [W-1:0] oe,   // device pin enable
  input  wire logic [W-1:0] ext,  // outside driver level
  output logic      [W-1:0] lvl   // resolved pin level
);
  // resolve each pin from both parties
  assign lvl = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

// >>> shared_pin_mux_io_ports_bench.sv
`timescale 1ns/1ps
`default_nettype none
module shared_pin_mux_io_ports_bench;
  import spm_pkg::*;
  logic        clk, arst_n;
  spm_req_t    req;
  logic [15:0] rdata, d;
  logic [3:0]  pa_in, pa_out, pa_oe, pa_x, sel_analog;
  logic [7:0]  pb_in, pb_out, pb_oe, pb_x, pc_in, pc_out, pc_oe, pc_x, sel_per_c;
  spm_periph_t per_b, per_c;
  logic [1:0]  cks;
  logic [2:0]  srcs;
  int          bad_count, checks_done, n, i;
  logic [15:0] rg[5];
  logic [15:0] ofs[5] = '{SPM_OFS_SEL_A, SPM_OFS_SEL_B, SPM_OFS_PORT_A, SPM_OFS_PORT_B,
                          SPM_OFS_PORT_C};
  logic [15:0] msk[5] = '{SPM_SEL_A_MASK, SPM_SEL_B_MASK, SPM_PORT_A_MASK, SPM_PORT_MASK,
                          SPM_PORT_MASK};

  spm_io_ports i_spm_io_ports (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .per_b(per_b),
    .per_c(per_c), .clk_out_sel(cks), .clk_srcs(srcs), .sel_analog(sel_analog),
    .sel_per_c(sel_per_c));
  spm_pin_world #(.W(4)) i_spm_pin_world_a (.out(pa_out), .oe(pa_oe), .ext(pa_x), .lvl(pa_in));
  spm_pin_world i_spm_pin_world_b (.out(pb_out), .oe(pb_oe), .ext(pb_x), .lvl(pb_in));
  spm_pin_world i_spm_pin_world_c (.out(pc_out), .oe(pc_oe), .ext(pc_x), .lvl(pc_in));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one access, strobe held across one rising edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] wd);
    @(negedge clk);
    req = '{rd: !w, wr: w, addr: a, wdata: wd};
    @(negedge clk);
    req = '0;
  endtask

  // per pin: {enable, value} from select, direction, data, peripheral
  function automatic logic [15:0] mux(input logic [7:0] s, t, v, po, pe);
    return {(s & pe) | (~s & t), (s & po) | (~s & v)};
  endfunction

  // readback: direction bits, then data or sampled level per pin
  function automatic logic [15:0] rbk(input logic [15:0] r, input logic [7:0] x,
                                      input logic [15:0] p);
    logic [7:0] lvl;
    lvl = (p[15:8] & p[7:0]) | (~p[15:8] & x);
    return {r[15:8], (r[15:8] & r[7:0]) | (~r[15:8] & lvl)};
  endfunction

  // model of all pins and registers against the design
  task automatic compare_all();
    logic [15:0] a, b, c, ex[5];
    logic [7:0]  sc;
    sc = (rg[1][7:0] ^ SPM_B_INV_MASK) & 8'hFD;
    a = mux({4'h0, rg[0][3:0]}, {4'h0, rg[2][11:8]}, {4'h0, rg[2][3:0]}, 8'h00, 8'h00);
    b = mux(rg[0][15:8], rg[3][15:8], rg[3][7:0], per_b.out, per_b.oe);
    c = mux(sc, rg[4][15:8], rg[4][7:0], per_c.out, per_c.oe);
    if (cks != 2'h0) begin
      c[9] = 1'b1;
      c[1] = srcs[cks - 2'h1];
    end
    ex = '{rg[0], rg[1], rbk(rg[2], {4'h0, pa_x}, a) & SPM_PORT_A_MASK,
           rbk(rg[3], pb_x, b), rbk(rg[4], pc_x, c)};
    repeat (4) @(negedge clk);
    check({4'h0, pa_oe, 4'h0, pa_out & pa_oe}, {4'h0, a[11:8], 4'h0, a[3:0] & a[11:8]});
    check({pb_oe, pb_out & pb_oe}, {b[15:8], b[7:0] & b[15:8]});
    check({pc_oe, pc_out & pc_oe}, {c[15:8], c[7:0] & c[15:8]});
    check({4'h0, sel_analog, sel_per_c & 8'hFD}, {4'h0, rg[0][3:0], sc});
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, ofs[k], 16'h0000);
      check(rdata, ex[k]);
    end
  endtask

  task automatic end_sim();
    $display("Checks: %0d, errors: %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(25 * 8000);
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    req = '0;
    per_b = '0;
    per_c = '0;
    pa_x = 4'h0;
    pb_x = 8'h00;
    pc_x = 8'h00;
    cks = 2'h0;
    srcs = 3'h0;
    bad_count = 0;
    checks_done = 0;
    rg = '{default: 16'h0000};
    void'($urandom(26436));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    compare_all();
    for (n = 0; n < 40; n++) begin
      {per_b, per_c} = 32'($urandom);
      {pa_x, pb_x, pc_x, srcs} = 23'($urandom);
      cks = n[1:0];
      for (i = 0; i < 5; i++) begin
        d = 16'($urandom);
        bus(1'b1, ofs[i], d);
        rg[i] = d & msk[i];
      end
      bus(1'b1, 16'h7094, 16'hFFFF);
      bus(1'b0, 16'h7094, 16'h0000);
      check(rdata, 16'h0000);
      if (n == 20) begin
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        rg = '{default: 16'h0000};
      end
      compare_all();
    end
    end_sim();
  end
endmodule
`default_nettype wire
